// ===== rtl/agu_add_defines.svh
// Constants for the address-register add and word-add execute block.
// Assumes the including file compiles after agu_add_pkg.
//
// Functional notes
// - Address add is a 24-bit two's-complement sum with a 24-bit result.
// - Immediates narrower than 24 bits are sign or zero extended first.
// - Address add never changes any condition code flag.
// - Destination is second pointer, a separate pointer, or offset reg.
// - Pointer plus pointer into the second pointer; 1 cycle, 1 word.
// - Pointer plus pointer into the offset register; 1 cycle, 1 word.
// - Unsigned 4-bit immediate added to a pointer in place; 1 cycle.
// - Unsigned 4-bit immediate plus pointer into offset reg; 1 cycle.
// - Signed 17-bit immediate plus pointer into pointer; 2 cycles, 2 words.
// - Full 24-bit immediate plus pointer into pointer; 3 cycles, 3 words.
// - Signed 16-bit data reg plus unsigned 16-bit immediate; 4 cycles.
// - Signed 16-bit data reg plus 24-bit immediate; 5 cycles, 3 words.
// - Two-operand immediate syntax decodes as three-operand, dest = source.
// - Word add takes 1 to 2 cycles and 1 to 2 words.
// - Address add takes 1 to 5 cycles and 1 to 3 words.
// - Word add short form zero extends 0 to 31; 1 cycle, 1 word.
// - Word add long form adds signed 16-bit immediate; 2 cycles, 2 words.
`ifndef AGU_ADD_DEFINES_SVH
`define AGU_ADD_DEFINES_SVH

// ****************************************
// Widths
// ****************************************
`define AGU_ADDR_W 24
`define AGU_WORD_W 16

// ****************************************
// Cycle counts per form
// ****************************************
`define AGU_CYC_ONE 3'h1
`define AGU_CYC_I17 3'h2
`define AGU_CYC_I24 3'h3
`define AGU_CYC_D16 3'h4
`define AGU_CYC_D24 3'h5
`define AGU_CYC_W16 3'h2

// ****************************************
// Opcode patterns and field positions
// ****************************************
`define AGU_PFX_TOP 5'h1c
`define AGU_PTRADD_TOP 4'h8
`define AGU_WADD_TOP 5'h08
`define AGU_SEL_01 2'h1
`define AGU_SHORT_LOW 4'h7
`define AGU_RR_MID 4'h9
`define AGU_RRN_MID 4'hd
`define AGU_I17_MID 3'h2
`define AGU_D16_MID 4'h6
`define AGU_W16_LOW 7'h40
`define AGU_W16_SHORT_SEL 2'h0

`endif

// ===== rtl/agu_add_pkg.sv
// Types for the address-register add and word-add execute block.
// Assumes nothing beyond a SystemVerilog compiler.
package agu_add_pkg;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPC = 2'b01,
    ST_EXT = 2'b10,
    ST_WAIT = 2'b11
  } state_t;

  // Decoded instruction forms
  typedef enum logic [3:0] {
    F_RR = 4'b0000,
    F_RRN = 4'b0001,
    F_I4 = 4'b0010,
    F_I4N = 4'b0011,
    F_I17 = 4'b0100,
    F_I24 = 4'b0101,
    F_D16 = 4'b0110,
    F_D24 = 4'b0111,
    F_W5 = 4'b1000,
    F_W16 = 4'b1001,
    F_BAD = 4'b1010
  } form_t;

  // Write-back target file
  typedef enum logic [1:0] {
    T_PTR = 2'b00,
    T_OFFSET = 2'b01,
    T_WORD = 2'b10
  } target_t;

endpackage

// ===== rtl/agu_add_exec.sv
// Decode and execute of the address-register add and word-add forms.
// Assumes a fetch stage offering one program word per cycle with valid,
// and register files whose current contents arrive as flat buses.
`timescale 1ns/10ps
`include "agu_add_defines.svh"

module agu_add_exec #(
  parameter int NPTR = 8,
  parameter int NDU = 8,
  parameter int NWR = 8
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_word_i,
  output logic instr_ready_o,
  input wire logic [NPTR*24-1:0] addr_pointer_file_i,
  input wire logic [NDU*16-1:0] data_unit_source_file_i,
  input wire logic [NWR*16-1:0] word_operand_reg_file_i,
  output logic wr_en_o,
  output agu_add_pkg::target_t wr_target_o,
  output logic [2:0] wr_idx_o,
  output logic [23:0] wr_data_o,
  output logic ccr_we_o,
  output logic decode_err_o,
  output logic busy_o
);

  // ****************************************
  // State
  // ****************************************
  agu_add_pkg::state_t state_q, state_d;
  agu_add_pkg::form_t form_q, form_d;
  logic [2:0] cnt_q, cnt_d;
  logic [2:0] src_q, src_d;
  logic [2:0] sec_q, sec_d;
  logic [2:0] wsel_q, wsel_d;
  logic [7:0] hi8_q, hi8_d;
  logic v_q, v_d;
  logic [15:0] lo_q, lo_d;
  logic fin, bad_fin;

  // ****************************************
  // First-word decode
  // ****************************************
  // Field extraction at fixed bit positions
  wire [15:0] w = instr_word_i;
  wire [2:0] w_src = {w[3], w[1], w[0]};
  wire [2:0] w_sec = {w[7], w[4], w[2]};
  wire [2:0] w_wsel = w[9:7];
  wire [7:0] w_hi8 = {w[10:8], w[6], w[3:0]};
  wire w_sel01 = (w[6:5] == `AGU_SEL_01);
  wire is_pfx = (w[15:11] == `AGU_PFX_TOP) && !w[7] &&
                (w[5:4] == 2'b11);
  wire is_ptr_add = (w[15:12] == `AGU_PTRADD_TOP);
  wire is_wadd = (w[15:11] == `AGU_WADD_TOP);
  wire is_short = is_ptr_add && (w[7:4] == `AGU_SHORT_LOW);
  wire is_rr = is_ptr_add && (w[11:8] == `AGU_RR_MID) && w_sel01;
  wire is_rrn = is_ptr_add && (w[11:8] == `AGU_RRN_MID) && w_sel01;
  wire is_i17 = is_ptr_add && (w[10:8] == `AGU_I17_MID) && w_sel01;
  wire is_d16 = is_ptr_add && (w[11:8] == `AGU_D16_MID) && w_sel01;
  wire is_w5 = is_wadd && !w[10] && (w[6:5] == `AGU_W16_SHORT_SEL);
  wire is_w16 = is_wadd && w[10] && (w[6:0] == `AGU_W16_LOW);

  // Form of a stand-alone opcode word
  agu_add_pkg::form_t dec_form;
  always_comb begin
    if (is_rr) begin
      dec_form = agu_add_pkg::F_RR;
    end else if (is_rrn) begin
      dec_form = agu_add_pkg::F_RRN;
    end else if (is_short) begin
      dec_form = w[2] ? agu_add_pkg::F_I4N : agu_add_pkg::F_I4;
    end else if (is_i17) begin
      dec_form = agu_add_pkg::F_I17;
    end else if (is_d16) begin
      dec_form = agu_add_pkg::F_D16;
    end else if (is_w5) begin
      dec_form = agu_add_pkg::F_W5;
    end else if (is_w16) begin
      dec_form = agu_add_pkg::F_W16;
    end else begin
      dec_form = agu_add_pkg::F_BAD;
    end
  end

  // Opcode following a prefix word: only the long forms are legal
  agu_add_pkg::form_t pfx_form;
  assign pfx_form = (is_i17 && !w[11]) ? agu_add_pkg::F_I24 :
                    is_d16 ? agu_add_pkg::F_D24 :
                    agu_add_pkg::F_BAD;

  // ****************************************
  // Effective fields at the finishing cycle
  // ****************************************
  wire in_idle = (state_q == agu_add_pkg::ST_IDLE);
  wire in_ext = (state_q == agu_add_pkg::ST_EXT);
  agu_add_pkg::form_t cur_form;
  assign cur_form = in_idle ? dec_form : form_q;
  wire [2:0] cur_src = in_idle ? w_src : src_q;
  wire [2:0] cur_sec = in_idle ? w_sec : sec_q;
  wire [2:0] cur_wsel = in_idle ? w_wsel : wsel_q;
  wire [15:0] cur_lo = in_ext ? w : lo_q;

  // Total cycles per form, counted from the first word taken
  logic [2:0] need_cyc;
  always_comb begin
    unique case (form_q)
      agu_add_pkg::F_I17: need_cyc = `AGU_CYC_I17;
      agu_add_pkg::F_I24: need_cyc = `AGU_CYC_I24;
      agu_add_pkg::F_D16: need_cyc = `AGU_CYC_D16;
      agu_add_pkg::F_D24: need_cyc = `AGU_CYC_D24;
      agu_add_pkg::F_W16: need_cyc = `AGU_CYC_W16;
      default: need_cyc = `AGU_CYC_ONE;
    endcase
  end
  wire [2:0] cnt_inc = cnt_q + 3'h1;
  wire cyc_done = (cnt_inc == need_cyc);

  // ****************************************
  // Operand fetch and arithmetic
  // ****************************************
  // Register file selection
  wire [23:0] ptr_src = addr_pointer_file_i[cur_src*24 +: 24];
  wire [23:0] ptr_sec = addr_pointer_file_i[cur_sec*24 +: 24];
  wire [15:0] du_val = data_unit_source_file_i[cur_sec*16 +: 16];
  wire [15:0] wo_val = word_operand_reg_file_i[cur_wsel*16 +: 16];
  // Widened immediates and data register
  wire [23:0] imm4 = {20'h0_0000, w[11:8]};
  wire [23:0] imm17 = {{7{v_q}}, v_q, cur_lo};
  wire [23:0] imm24 = {hi8_q, cur_lo};
  wire [23:0] du_sx = {{8{du_val[15]}}, du_val};
  wire [23:0] lo_zx = {8'h00, cur_lo};

  // Sum and destination per form
  logic [23:0] sum;
  agu_add_pkg::target_t tgt;
  logic [2:0] tidx;
  always_comb begin
    sum = 24'h00_0000;
    tgt = agu_add_pkg::T_PTR;
    tidx = cur_sec;
    unique case (cur_form)
      agu_add_pkg::F_RR: begin
        sum = ptr_src + ptr_sec;
      end
      agu_add_pkg::F_RRN: begin
        sum = ptr_src + ptr_sec;
        tgt = agu_add_pkg::T_OFFSET;
      end
      agu_add_pkg::F_I4: begin
        sum = ptr_src + imm4;
        tidx = cur_src;
      end
      agu_add_pkg::F_I4N: begin
        sum = ptr_src + imm4;
        tgt = agu_add_pkg::T_OFFSET;
      end
      agu_add_pkg::F_I17: begin
        sum = ptr_src + imm17;
      end
      agu_add_pkg::F_I24: begin
        sum = ptr_src + imm24;
      end
      agu_add_pkg::F_D16: begin
        sum = du_sx + lo_zx;
        tidx = cur_src;
      end
      agu_add_pkg::F_D24: begin
        sum = du_sx + imm24;
        tidx = cur_src;
      end
      agu_add_pkg::F_W5: begin
        sum = {8'h00, 16'(wo_val + {11'h000, w[4:0]})};
        tgt = agu_add_pkg::T_WORD;
        tidx = cur_wsel;
      end
      agu_add_pkg::F_W16: begin
        sum = {8'h00, 16'(wo_val + cur_lo)};
        tgt = agu_add_pkg::T_WORD;
        tidx = cur_wsel;
      end
      default: begin
        sum = 24'h00_0000;
      end
    endcase
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Walks prefix, opcode and extension words, then burns the cycles left
  always_comb begin
    state_d = state_q;
    form_d = form_q;
    cnt_d = cnt_q;
    src_d = src_q;
    sec_d = sec_q;
    wsel_d = wsel_q;
    hi8_d = hi8_q;
    v_d = v_q;
    lo_d = lo_q;
    fin = 1'b0;
    bad_fin = 1'b0;
    unique case (state_q)
      agu_add_pkg::ST_IDLE: begin
        if (instr_valid_i) begin
          cnt_d = 3'h1;
          src_d = w_src;
          sec_d = w_sec;
          wsel_d = w_wsel;
          v_d = w[11];
          form_d = dec_form;
          if (is_pfx) begin
            hi8_d = w_hi8;
            state_d = agu_add_pkg::ST_OPC;
          end else if (dec_form == agu_add_pkg::F_BAD) begin
            bad_fin = 1'b1;
          end else if (dec_form == agu_add_pkg::F_I17 ||
                       dec_form == agu_add_pkg::F_D16 ||
                       dec_form == agu_add_pkg::F_W16) begin
            state_d = agu_add_pkg::ST_EXT;
          end else begin
            fin = 1'b1;
          end
        end
      end
      agu_add_pkg::ST_OPC: begin
        if (instr_valid_i) begin
          cnt_d = cnt_inc;
          src_d = w_src;
          sec_d = w_sec;
          form_d = pfx_form;
          if (pfx_form == agu_add_pkg::F_BAD) begin
            bad_fin = 1'b1;
            state_d = agu_add_pkg::ST_IDLE;
          end else begin
            state_d = agu_add_pkg::ST_EXT;
          end
        end
      end
      agu_add_pkg::ST_EXT: begin
        if (instr_valid_i) begin
          cnt_d = cnt_inc;
          lo_d = w;
          if (cyc_done) begin
            fin = 1'b1;
            state_d = agu_add_pkg::ST_IDLE;
          end else begin
            state_d = agu_add_pkg::ST_WAIT;
          end
        end
      end
      agu_add_pkg::ST_WAIT: begin
        cnt_d = cnt_inc;
        if (cyc_done) begin
          fin = 1'b1;
          state_d = agu_add_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= agu_add_pkg::ST_IDLE;
      form_q <= agu_add_pkg::F_BAD;
      cnt_q <= 3'h0;
      src_q <= 3'h0;
      sec_q <= 3'h0;
      wsel_q <= 3'h0;
      hi8_q <= 8'h00;
      v_q <= 1'b0;
      lo_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      form_q <= form_d;
      cnt_q <= cnt_d;
      src_q <= src_d;
      sec_q <= sec_d;
      wsel_q <= wsel_d;
      hi8_q <= hi8_d;
      v_q <= v_d;
      lo_q <= lo_d;
    end
  end

  // ****************************************
  // Write-back outputs
  // ****************************************
  // Result registered one edge after the finishing cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_en_o <= 1'b0;
      wr_target_o <= agu_add_pkg::T_PTR;
      wr_idx_o <= 3'h0;
      wr_data_o <= 24'h00_0000;
      decode_err_o <= 1'b0;
    end else begin
      wr_en_o <= fin;
      decode_err_o <= bad_fin;
      if (fin) begin
        wr_target_o <= tgt;
        wr_idx_o <= tidx;
        wr_data_o <= sum;
      end
    end
  end

  // Flags are never written by these forms
  assign ccr_we_o = 1'b0;
  assign instr_ready_o = (state_q != agu_add_pkg::ST_WAIT);
  assign busy_o = !in_idle;

endmodule

// ===== testbench/agu_add_exec_sva.sv
// Checker for the address add execute block, bound to its ports.
// Assumes agu_add_pkg is compiled first.
`timescale 1ns/10ps
module agu_add_exec_chk #(
  parameter int NPTR = 8,
  parameter int NDU = 8,
  parameter int NWR = 8
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_word_i,
  input wire logic instr_ready_o,
  input wire logic [NPTR*24-1:0] addr_pointer_file_i,
  input wire logic [NDU*16-1:0] data_unit_source_file_i,
  input wire logic [NWR*16-1:0] word_operand_reg_file_i,
  input wire logic wr_en_o,
  input wire agu_add_pkg::target_t wr_target_o,
  input wire logic [2:0] wr_idx_o,
  input wire logic [23:0] wr_data_o,
  input wire logic ccr_we_o,
  input wire logic decode_err_o,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  // ****
  // First word decode
  // ****
  wire logic [15:0] w = instr_word_i;
  wire logic first_w = instr_valid_i && instr_ready_o && !busy_o;
  wire logic [2:0] src_w = {w[3], w[1], w[0]};
  wire logic [2:0] dst_w = {w[7], w[4], w[2]};
  wire logic [23:0] ptr_s = addr_pointer_file_i[src_w*24 +: 24];
  wire logic [23:0] rr_sum = ptr_s + addr_pointer_file_i[dst_w*24 +: 24];
  wire logic [23:0] i4_sum = ptr_s + {20'h0_0000, w[11:8]};
  wire logic [15:0] w5_sum = word_operand_reg_file_i[w[9:7]*16 +: 16]
    + {11'h000, w[4:0]};
  wire logic is_rr = w[15:8] == 8'h89 && w[6:5] == 2'h1;
  wire logic is_rrn = w[15:8] == 8'h8d && w[6:5] == 2'h1;
  wire logic is_i4 = w[15:12] == 4'h8 && w[7:4] == 4'h7;
  wire logic is_w5 = w[15:10] == 6'h10 && w[6:5] == 2'h0;

  chk_no_flags: assert property (ccr_we_o == 1'h0)
    else $error("flag write enable raised");
  chk_one_result: assert property (!(wr_en_o && decode_err_o))
    else $error("write and decode error together");
  chk_wait_busy: assert property (!instr_ready_o |-> busy_o)
    else $error("not ready while idle");
  chk_wait_len: assert property ($fell(instr_ready_o)
    |=> !instr_ready_o ##1 instr_ready_o)
    else $error("wait length wrong");
  chk_wait_end: assert property ($rose(instr_ready_o) |-> wr_en_o)
    else $error("wait ended without write");
  chk_data_hold: assert property (!wr_en_o |-> $stable(wr_data_o))
    else $error("result changed without write");
  chk_rr_sum: assert property (first_w && is_rr |=> wr_en_o
    && wr_target_o == agu_add_pkg::T_PTR && wr_data_o == $past(rr_sum))
    else $error("pointer add result wrong");
  chk_rrn_sum: assert property (first_w && is_rrn |=> wr_en_o
    && wr_target_o == agu_add_pkg::T_OFFSET && wr_data_o == $past(rr_sum))
    else $error("offset add result wrong");
  chk_short_imm: assert property (first_w && is_i4
    |=> wr_en_o && wr_data_o == $past(i4_sum))
    else $error("short immediate result wrong");
  chk_short_word: assert property (first_w && is_w5 |=> wr_en_o
    && wr_data_o == {8'h00, $past(w5_sum)})
    else $error("short word add result wrong");
  cov_word: cover property (wr_en_o && wr_target_o == agu_add_pkg::T_WORD);
  cov_offs: cover property (wr_en_o && wr_target_o == agu_add_pkg::T_OFFSET);
  cov_wait: cover property ($fell(instr_ready_o));
  cov_err: cover property (decode_err_o);
endmodule

bind agu_add_exec agu_add_exec_chk #(.NPTR(NPTR), .NDU(NDU), .NWR(NWR))
  u_chk (.*);

// ===== testbench/agu_reg_files_model.sv
// Register files behind the address add block.
// Assumes one write port from the block; the bench preloads contents.
`timescale 1ns/10ps
module agu_reg_files_model (
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire agu_add_pkg::target_t wr_target_i,
  input wire logic [2:0] wr_idx_i,
  input wire logic [23:0] wr_data_i,
  output logic [191:0] ptr_o,
  output logic [127:0] du_o,
  output logic [127:0] wo_o
);
  logic [23:0] ptr_q [8];
  logic [15:0] du_q [8];
  logic [15:0] wo_q [8];
  logic [23:0] offset_q;
  // Flatten contents onto buses
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      ptr_o[k*24 +: 24] = ptr_q[k];
      du_o[k*16 +: 16] = du_q[k];
      wo_o[k*16 +: 16] = wo_q[k];
    end
  end
  // Route each write to its file
  always @(posedge clk_i) begin
    if (wr_en_i) begin
      case (wr_target_i)
        agu_add_pkg::T_PTR: ptr_q[wr_idx_i] <= wr_data_i;
        agu_add_pkg::T_OFFSET: offset_q <= wr_data_i;
        default: wo_q[wr_idx_i] <= wr_data_i[15:0];
      endcase
    end
  end
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the address add execute block.
// Assumes the register file model and checker are compiled first.
`timescale 1ns/10ps
module tb;
  localparam int LIMIT = 3000;
  logic clk_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic instr_valid_i = 1'h0;
  logic [15:0] instr_word_i = 16'h0000;
  logic instr_ready_o, wr_en_o, ccr_we_o, decode_err_o, busy_o;
  agu_add_pkg::target_t wr_target_o;
  logic [2:0] wr_idx_o;
  logic [23:0] wr_data_o;
  logic [191:0] ptr_f;
  logic [127:0] du_f, wo_f;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;

  always #12.5 clk_i = ~clk_i;

  agu_add_exec u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i),
    .instr_ready_o(instr_ready_o), .addr_pointer_file_i(ptr_f),
    .data_unit_source_file_i(du_f), .word_operand_reg_file_i(wo_f),
    .wr_en_o(wr_en_o), .wr_target_o(wr_target_o), .wr_idx_o(wr_idx_o),
    .wr_data_o(wr_data_o), .ccr_we_o(ccr_we_o),
    .decode_err_o(decode_err_o), .busy_o(busy_o));
  agu_reg_files_model u_rf (.clk_i(clk_i), .wr_en_i(wr_en_o),
    .wr_target_i(wr_target_o), .wr_idx_i(wr_idx_o), .wr_data_i(wr_data_o),
    .ptr_o(ptr_f), .du_o(du_f), .wo_o(wo_f));

  task automatic final_report();
    $display("Mismatches %0d, comparisons %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Send words, then wait for the result
  task automatic run(input logic [15:0] w [3], input int n, input int c,
      input logic [23:0] e, input logic [1:0] t, input logic [2:0] i);
    int k;
    k = 0;
    @(posedge clk_i);
    instr_valid_i <= 1'h1;
    instr_word_i <= w[0];
    while (k < 12) begin
      @(posedge clk_i);
      k++;
      if (k < n) instr_word_i <= w[k];
      else instr_valid_i <= 1'h0;
      #1;
      if (wr_en_o === 1'h1 || decode_err_o === 1'h1) break;
    end
    if (c == 0) begin
      chk_val(24'(decode_err_o), 24'h00_0001);
    end else begin
      chk_val(24'(k), 24'(c));
      chk_val(wr_data_o, e);
      chk_val(24'(wr_target_o), 24'(t));
      if (t != 2'h1) chk_val(24'(wr_idx_o), 24'(i));
      chk_val(24'(ccr_we_o), 24'h00_0000);
    end
  endtask

  // Build one instruction of form f with its expected result
  task automatic do_form(input int f, input bit corner);
    logic [15:0] w [3];
    logic [2:0] s, d, i;
    logic [23:0] imm, a, b, e, sx;
    logic [15:0] ww;
    logic [7:0] tl;
    logic [1:0] t;
    int n, c;
    s = 3'($urandom);
    d = corner ? s : 3'($urandom);
    imm = corner ? 24'hff_ffff : 24'($urandom);
    @(posedge clk_i);
    #1;
    a = u_rf.ptr_q[s];
    b = u_rf.ptr_q[d];
    sx = {{8{u_rf.du_q[d][15]}}, u_rf.du_q[d]};
    ww = u_rf.wo_q[d];
    tl = {d[2], 2'h1, d[1], s[2], d[0], s[1:0]};
    w = '{default: 16'h0000};
    w[0] = {8'h89, tl};
    e = a + b;
    n = 1;
    c = 1;
    t = 2'h0;
    i = d;
    case (f)
      1: begin
        w[0] = {8'h8d, tl};
        t = 2'h1;
      end
      2, 3: begin
        w[0] = {4'h8, imm[3:0], 4'h7, s[2], f == 3, s[1:0]};
        e = a + {20'h0_0000, imm[3:0]};
        t = {1'h0, f == 3};
        i = s;
      end
      4, 6, 9: begin
        w[0] = f == 4 ? {4'h8, imm[16], 3'h2, tl} : {8'h86, tl};
        w[1] = imm[15:0];
        e = f == 4 ? a + {{7{imm[16]}}, imm[16:0]} : sx + imm[15:0];
        n = 2;
        c = f == 6 ? 4 : 2;
        i = f == 6 ? s : d;
        if (f == 9) w[0] = {5'h08, 1'h1, d, 7'h40};
        if (f == 9) e = {8'h00, ww + imm[15:0]};
        if (f == 9) t = 2'h2;
      end
      5, 7: begin
        w[0] = {5'h1c, imm[23:21], 1'h0, imm[20], 2'h3, imm[19:16]};
        w[1] = {f == 5 ? 8'h82 : 8'h86, tl};
        w[2] = imm[15:0];
        e = (f == 5 ? a : sx) + imm;
        n = 3;
        c = f - 2;
        i = f == 5 ? d : s;
      end
      8: begin
        w[0] = {5'h08, 1'h0, d, 2'h0, imm[4:0]};
        e = {8'h00, ww + {11'h000, imm[4:0]}};
        t = 2'h2;
      end
      10: begin
        w[0] = 16'hffff;
        c = 0;
      end
      11: begin
        w[1] = w[0];
        w[0] = {5'h1c, 11'h030};
        n = 2;
        c = 0;
      end
      default: ;
    endcase
    run(w, n, c, e, t, i);
  endtask

  // Cut a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > LIMIT) begin
      mismatches++;
      final_report();
    end
  end

  // Preload files, reset, then all forms
  initial begin
    void'($urandom(46));
    for (int k = 0; k < 8; k++) begin
      u_rf.ptr_q[k] = 24'($urandom);
      u_rf.du_q[k] = 16'($urandom);
      u_rf.wo_q[k] = 16'($urandom);
    end
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'h1;
    for (int r = 0; r < 6; r++) begin
      if (r == 3) begin
        @(posedge clk_i);
        arst_n_i <= 1'h0;
        @(posedge clk_i);
        #1;
        chk_val(wr_data_o, 24'h00_0000);
        arst_n_i <= 1'h1;
      end
      for (int f = 0; f < 12; f++) do_form(f, r == 0);
    end
    final_report();
  end
endmodule
